// ==== hw/kic_axil_slave.sv ====
`timescale 1ns/1ns
module kic_axil_slave
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [31:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [31:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   output logic             wr_en,
   output logic [31:0]      wr_addr,
   output logic [7:0]       wr_data,
   output logic             wr_be,
   input  wire logic        wr_hit,
   input  wire logic [7:0]  rd_data,
   input  wire logic        rd_hit
);

   // ----------------------------------------------------------------
   // Channel handshakes
   // ----------------------------------------------------------------
   logic aw_held_reg, w_held_reg, aw_take, w_take, ar_take;
   logic aw_held_next, w_held_next, bvalid_next, rvalid_next;

   // Address and data are held separately, so either may come first.
   assign aw_take      = awvalid & awready;
   assign w_take       = wvalid & wready;
   assign ar_take      = arvalid & arready;
   assign wr_en        = aw_held_reg & w_held_reg & ~bvalid;
   assign aw_held_next = (aw_held_reg | aw_take) & ~wr_en;
   assign w_held_next  = (w_held_reg | w_take) & ~wr_en;
   assign bvalid_next  = wr_en | (bvalid & ~bready);
   assign rvalid_next  = ar_take | (rvalid & ~rready);

   // Write path state; readiness is registered from the next state.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awready     <= 1'b0;
         wready      <= 1'b0;
         bvalid      <= 1'b0;
      end
      else
      begin
         aw_held_reg <= aw_held_next;
         w_held_reg  <= w_held_next;
         awready     <= ~aw_held_next & ~bvalid_next;
         wready      <= ~w_held_next & ~bvalid_next;
         bvalid      <= bvalid_next;
      end
   end

   // Captured write payload and write response.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_addr <= 32'h00000000;
         wr_data <= 8'h00;
         wr_be   <= 1'b0;
         bresp   <= kic_pkg::RESP_OK;
      end
      else
      begin
         if (aw_take)
            wr_addr <= awaddr;
         if (w_take)
         begin
            wr_data <= wdata[7:0];
            wr_be   <= wstrb[0];
         end
         if (wr_en)
            bresp <= wr_hit ? kic_pkg::RESP_OK : kic_pkg::RESP_DEC;
      end
   end

   // Read path: data is sampled at the address handshake.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h00000000;
         rresp   <= kic_pkg::RESP_OK;
      end
      else
      begin
         arready <= ~rvalid_next;
         rvalid  <= rvalid_next;
         if (ar_take)
         begin
            rdata <= {24'h000000, rd_data};
            rresp <= rd_hit ? kic_pkg::RESP_OK : kic_pkg::RESP_DEC;
         end
      end
   end

endmodule : kic_axil_slave

// ==== hw/kic_pin_sync.sv ====
`timescale 1ns/1ns
module kic_pin_sync
(
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic [kic_pkg::NPINS-1:0]  pin_in,
   output logic      [kic_pkg::NPINS-1:0]  pin_lvl
);

   // ----------------------------------------------------------------
   // Two-stage synchronisers, one per pin
   // ----------------------------------------------------------------
   logic [kic_pkg::NPINS-1:0] meta_reg;

   genvar g;
   generate
      for (g = 0; g < kic_pkg::NPINS; g++)
      begin : g_sync
         // The first stage feeds only the second stage.
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               meta_reg[g] <= 1'b0;
               pin_lvl[g]  <= 1'b0;
            end
            else
            begin
               meta_reg[g] <= pin_in[g];
               pin_lvl[g]  <= meta_reg[g];
            end
         end
      end
   endgenerate

endmodule : kic_pin_sync

// ==== hw/kic_pkg.sv ====
package kic_pkg;

   // ----------------------------------------------------------------
   // Sizes, offsets and field positions
   // ----------------------------------------------------------------
   localparam int          NPINS     = 8;
   localparam logic [4:0]  OFF_SCR   = 5'h00;
   localparam logic [4:0]  OFF_IER   = 5'h04;
   localparam logic [4:0]  OFF_IPR   = 5'h08;
   localparam logic [4:0]  OFF_BFC   = 5'h0c;
   localparam logic [4:0]  OFF_DIR   = 5'h10;
   localparam logic [4:0]  OFF_DAT   = 5'h14;
   localparam int          BIT_PEND  = 3;
   localparam int          BIT_ACK   = 2;
   localparam int          BIT_MASK  = 1;
   localparam int          BIT_MODE  = 0;
   localparam int          BIT_BCE   = 0;

   // ----------------------------------------------------------------
   // Reset values, vector and bus answers
   // ----------------------------------------------------------------
   localparam logic [7:0]  RST_PINS  = 8'h00;
   localparam logic        RST_BIT   = 1'b0;
   localparam logic [7:0]  RST_OE_N  = 8'hff;
   localparam logic [15:0] VEC_ADDR  = 16'hffe0;
   localparam logic [1:0]  RESP_OK   = 2'b00;
   localparam logic [1:0]  RESP_DEC  = 2'b11;

   // Full-address match against one register offset.
   function automatic logic kic_hit(input logic [31:0] addr, input logic [4:0] off);
      return addr == {27'h0000000, off};
   endfunction : kic_hit

endpackage : kic_pkg

// ==== hw/kic_top.sv ====
`timescale 1ns/1ns
module kic_top
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [31:0] s_axil_awaddr,
   input  wire logic        s_axil_awvalid,
   output logic             s_axil_awready,
   input  wire logic [31:0] s_axil_wdata,
   input  wire logic [3:0]  s_axil_wstrb,
   input  wire logic        s_axil_wvalid,
   output logic             s_axil_wready,
   output logic [1:0]       s_axil_bresp,
   output logic             s_axil_bvalid,
   input  wire logic        s_axil_bready,
   input  wire logic [31:0] s_axil_araddr,
   input  wire logic        s_axil_arvalid,
   output logic             s_axil_arready,
   output logic [31:0]      s_axil_rdata,
   output logic [1:0]       s_axil_rresp,
   output logic             s_axil_rvalid,
   input  wire logic        s_axil_rready,
   input  wire logic [7:0]  pin_in,
   output logic      [7:0]  pin_out,
   output logic      [7:0]  pin_oe_n,
   output logic      [7:0]  pull_up_en,
   output logic      [7:0]  pull_down_en,
   input  wire logic        vector_fetch,
   input  wire logic [15:0] fetch_addr,
   input  wire logic        break_state,
   output logic             irq_req,
   output logic             wake_req
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic        wr_en;
   logic [31:0] wr_addr;
   logic [7:0]  wr_data;
   logic        wr_be;
   logic        wr_hit;
   logic [7:0]  rd_data;
   logic        rd_hit;
   logic [7:0]  pin_lvl;
   logic [7:0]  lvl_prev_reg;
   logic [7:0]  pin_irq_enable_bits;
   logic [7:0]  pin_polarity_bits;
   logic [7:0]  port_direction;
   logic [7:0]  port_data_reg;
   logic        trigger_sensitivity;
   logic        request_mask;
   logic        break_clear_enable;
   logic        latch_reg;
   logic        latch_next;
   logic        any_q_reg;
   logic [7:0]  asserted;
   logic [7:0]  act_edge;
   logic        any_now;
   logic        edge_set;
   logic        pending_flag;
   logic        request_acknowledge;
   logic        sw_ack_ok;
   logic        vec_ack;
   logic        ack;
   logic        wr_scr;
   logic        wr_ier;
   logic        wr_ipr;
   logic        wr_bfc;
   logic        wr_dir;
   logic        wr_dat;
   logic [7:0]  scr_rd;
   logic [7:0]  dat_rd;

   // ----------------------------------------------------------------
   // Register bus and pin synchronisers
   // ----------------------------------------------------------------

   // AXI4-Lite slave; register writes land one cycle after both halves.
   kic_axil_slave u_bus
   (
      .clk     (clk),
      .rst     (rst),
      .awaddr  (s_axil_awaddr),
      .awvalid (s_axil_awvalid),
      .awready (s_axil_awready),
      .wdata   (s_axil_wdata),
      .wstrb   (s_axil_wstrb),
      .wvalid  (s_axil_wvalid),
      .wready  (s_axil_wready),
      .bresp   (s_axil_bresp),
      .bvalid  (s_axil_bvalid),
      .bready  (s_axil_bready),
      .araddr  (s_axil_araddr),
      .arvalid (s_axil_arvalid),
      .arready (s_axil_arready),
      .rdata   (s_axil_rdata),
      .rresp   (s_axil_rresp),
      .rvalid  (s_axil_rvalid),
      .rready  (s_axil_rready),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_be   (wr_be),
      .wr_hit  (wr_hit),
      .rd_data (rd_data),
      .rd_hit  (rd_hit)
   );

   // Pins come from outside the clock domain.
   kic_pin_sync u_sync
   (
      .clk     (clk),
      .rst     (rst),
      .pin_in  (pin_in),
      .pin_lvl (pin_lvl)
   );

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------

   // Write strobes; byte lane 0 carries every register.
   assign wr_scr = wr_en & wr_be & kic_pkg::kic_hit(wr_addr, kic_pkg::OFF_SCR);
   assign wr_ier = wr_en & wr_be & kic_pkg::kic_hit(wr_addr, kic_pkg::OFF_IER);
   assign wr_ipr = wr_en & wr_be & kic_pkg::kic_hit(wr_addr, kic_pkg::OFF_IPR);
   assign wr_bfc = wr_en & wr_be & kic_pkg::kic_hit(wr_addr, kic_pkg::OFF_BFC);
   assign wr_dir = wr_en & wr_be & kic_pkg::kic_hit(wr_addr, kic_pkg::OFF_DIR);
   assign wr_dat = wr_en & wr_be & kic_pkg::kic_hit(wr_addr, kic_pkg::OFF_DAT);

   // Any mapped offset answers OKAY, others a decode error.
   assign wr_hit = kic_pkg::kic_hit(wr_addr, kic_pkg::OFF_SCR)
                 | kic_pkg::kic_hit(wr_addr, kic_pkg::OFF_IER)
                 | kic_pkg::kic_hit(wr_addr, kic_pkg::OFF_IPR)
                 | kic_pkg::kic_hit(wr_addr, kic_pkg::OFF_BFC)
                 | kic_pkg::kic_hit(wr_addr, kic_pkg::OFF_DIR)
                 | kic_pkg::kic_hit(wr_addr, kic_pkg::OFF_DAT);
   assign rd_hit = kic_pkg::kic_hit(s_axil_araddr, kic_pkg::OFF_SCR)
                 | kic_pkg::kic_hit(s_axil_araddr, kic_pkg::OFF_IER)
                 | kic_pkg::kic_hit(s_axil_araddr, kic_pkg::OFF_IPR)
                 | kic_pkg::kic_hit(s_axil_araddr, kic_pkg::OFF_BFC)
                 | kic_pkg::kic_hit(s_axil_araddr, kic_pkg::OFF_DIR)
                 | kic_pkg::kic_hit(s_axil_araddr, kic_pkg::OFF_DAT);

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------

   // Status and control: mode and mask; pending and ack are not stored.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         trigger_sensitivity <= kic_pkg::RST_BIT;
         request_mask        <= kic_pkg::RST_BIT;
      end
      else if (wr_scr)
      begin
         trigger_sensitivity <= wr_data[kic_pkg::BIT_MODE];
         request_mask        <= wr_data[kic_pkg::BIT_MASK];
      end
   end

   // Per-pin enables and polarities.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pin_irq_enable_bits <= kic_pkg::RST_PINS;
         pin_polarity_bits   <= kic_pkg::RST_PINS;
      end
      else
      begin
         if (wr_ier)
            pin_irq_enable_bits <= wr_data;
         if (wr_ipr)
            pin_polarity_bits <= wr_data;
      end
   end

   // Break clear enable, port direction and port data.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         break_clear_enable <= kic_pkg::RST_BIT;
         port_direction     <= kic_pkg::RST_PINS;
         port_data_reg      <= kic_pkg::RST_PINS;
      end
      else
      begin
         if (wr_bfc)
            break_clear_enable <= wr_data[kic_pkg::BIT_BCE];
         if (wr_dir)
            port_direction <= wr_data;
         if (wr_dat)
            port_data_reg <= wr_data;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------

   // Pending ignores the mask; ack and the upper nibble read zero.
   assign scr_rd = {4'h0, pending_flag, 1'b0, request_mask,
                    trigger_sensitivity};

   // The pin level is visible only where the direction bit is clear.
   assign dat_rd = (port_direction & port_data_reg) | (~port_direction & pin_lvl);

   assign rd_data =
      kic_pkg::kic_hit(s_axil_araddr, kic_pkg::OFF_SCR) ? scr_rd :
      kic_pkg::kic_hit(s_axil_araddr, kic_pkg::OFF_IER) ? pin_irq_enable_bits :
      kic_pkg::kic_hit(s_axil_araddr, kic_pkg::OFF_IPR) ? pin_polarity_bits :
      kic_pkg::kic_hit(s_axil_araddr, kic_pkg::OFF_BFC) ? {7'h00, break_clear_enable} :
      kic_pkg::kic_hit(s_axil_araddr, kic_pkg::OFF_DIR) ? port_direction :
      kic_pkg::kic_hit(s_axil_araddr, kic_pkg::OFF_DAT) ? dat_rd : 8'h00;

   // ----------------------------------------------------------------
   // Detection
   // ----------------------------------------------------------------

   // A pin is asserted when enabled and its level equals its polarity.
   assign asserted = pin_irq_enable_bits & ~(pin_lvl ^ pin_polarity_bits);
   assign any_now  = |asserted;

   // An active edge is a change into the asserted level between samples.
   assign act_edge = asserted & (pin_lvl ^ lvl_prev_reg);

   // Edges count only when no enabled pin was already asserted.
   assign edge_set = (|act_edge) & ~any_q_reg;

   // Previous samples for edge and busy detection.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         lvl_prev_reg <= kic_pkg::RST_PINS;
         any_q_reg    <= 1'b0;
      end
      else
      begin
         lvl_prev_reg <= pin_lvl;
         any_q_reg    <= any_now;
      end
   end

   // ----------------------------------------------------------------
   // Request latch and acknowledge
   // ----------------------------------------------------------------

   // Software acknowledge is blocked in break unless clear is enabled.
   assign request_acknowledge = wr_scr & wr_data[kic_pkg::BIT_ACK];
   assign sw_ack_ok = request_acknowledge & (~break_state | break_clear_enable);
   assign vec_ack   = vector_fetch & (fetch_addr == kic_pkg::VEC_ADDR);
   assign ack       = sw_ack_ok | vec_ack;

   // A new edge wins over an acknowledge in the same cycle.
   assign latch_next = edge_set | (latch_reg & ~ack);

   // Level mode keeps the request up while any pin stays asserted.
   assign pending_flag = latch_reg | (trigger_sensitivity & any_q_reg);

   // The latch; reset drops it even with a pin held asserted.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         latch_reg <= 1'b0;
      else
         latch_reg <= latch_next;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   // Request to the processor and wake-up from the low-power modes.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         irq_req  <= 1'b0;
         wake_req <= 1'b0;
      end
      else
      begin
         irq_req  <= pending_flag & ~request_mask;
         wake_req <= pending_flag & ~request_mask;
      end
   end

   // Pad controls: an enabled pin never drives and gets its pull.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pin_out      <= kic_pkg::RST_PINS;
         pin_oe_n     <= kic_pkg::RST_OE_N;
         pull_up_en   <= kic_pkg::RST_PINS;
         pull_down_en <= kic_pkg::RST_PINS;
      end
      else
      begin
         pin_out      <= port_data_reg;
         pin_oe_n     <= ~(port_direction & ~pin_irq_enable_bits);
         pull_up_en   <= pin_irq_enable_bits & ~pin_polarity_bits;
         pull_down_en <= pin_irq_enable_bits & pin_polarity_bits;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Acknowledge written in break without the clear enable.
   sequence s_break_ack;
      request_acknowledge && break_state && !break_clear_enable && !vec_ack;
   endsequence

   // A fresh edge with no pin already asserted.
   sequence s_fresh_edge;
      (|act_edge) && !any_q_reg;
   endsequence

   a_pull_choice: assert property (
      1'b1 |=> ((pull_up_en | pull_down_en) == $past(pin_irq_enable_bits))
               && ((pull_up_en & pull_down_en) == 8'h00))
      else $error("Pull devices disagree with enables.");

   a_edge_latch: assert property (
      s_fresh_edge |=> latch_reg ##1 irq_req || request_mask)
      else $error("Active edge did not latch a request.");

   a_busy_block: assert property (
      !latch_reg && any_q_reg |=> !latch_reg)
      else $error("Edge latched while another pin was asserted.");

   a_level_hold: assert property (
      trigger_sensitivity && any_q_reg |-> pending_flag)
      else $error("Level request dropped while pin asserted.");

   a_level_release: assert property (
      trigger_sensitivity && !latch_reg && !any_q_reg |-> !pending_flag)
      else $error("Level request held after ack and release.");

   a_ack_clear: assert property (
      ack && !edge_set |=> !latch_reg)
      else $error("Acknowledge did not clear the latch.");

   a_break_guard: assert property (
      s_break_ack ##0 latch_reg |=> latch_reg)
      else $error("Break-state acknowledge cleared the latch.");

   a_mask_gate: assert property (
      request_mask |=> !irq_req && !wake_req)
      else $error("Masked request reached the processor.");

   a_scr_zero: assert property (
      scr_rd[7:4] == 4'h0 && !scr_rd[kic_pkg::BIT_ACK])
      else $error("Unused or acknowledge bits read nonzero.");

   a_input_force: assert property (
      1'b1 |=> (~pin_oe_n & $past(pin_irq_enable_bits)) == 8'h00)
      else $error("Enabled keypad pin is driven.");

endmodule : kic_top

// ==== verif/kic_keys.sv ====
`timescale 1ns/1ns
module kic_keys
(
   input  wire logic       clk,
   input  wire logic [7:0] key_on,
   input  wire logic [7:0] key_lvl,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe_n,
   input  wire logic [7:0] pull_up_en,
   input  wire logic [7:0] pull_down_en,
   output logic      [7:0] pin_lvl
);
   logic [7:0] float_reg = 8'h00;

   // A pin nobody holds shows the inverse of its last level, so a missing pull shows up.
   always @(posedge clk)
      float_reg <= ~pin_lvl;

   // Port driver first, then a closed key, then the pull devices.
   always_comb
      for (int i = 0; i < 8; i++)
         pin_lvl[i] = !pin_oe_n[i] ? pin_out[i] : key_on[i] ? key_lvl[i] :
                      pull_up_en[i] ? 1'b1 : pull_down_en[i] ? 1'b0 : float_reg[i];
endmodule : kic_keys

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
   logic        clk, rst, awv, wv, bv, br, arv, rv, rr, awr, wr_r, arr, vf, brk, irq, wake;
   logic [31:0] awa, wd, ara, rd_d, d;
   logic [1:0]  bresp, rresp, r;
   logic [7:0]  pin, po, oen, pu, pd, kon, klv;
   logic [15:0] fa;
   int          miscompares, n_tests, cycles;
   logic [31:0] ra [5] = '{32'h00, 32'h04, 32'h08, 32'h0c, 32'h1c};
   logic [31:0] rw [5] = '{32'hff, 32'h1ff, 32'ha5, 32'h01, 32'h55};
   logic [31:0] re [5] = '{32'h03, 32'hff, 32'ha5, 32'h01, 32'h00};

   kic_top dut (.clk(clk), .rst(rst), .s_axil_awaddr(awa), .s_axil_awvalid(awv),
      .s_axil_awready(awr), .s_axil_wdata(wd), .s_axil_wstrb(4'hf), .s_axil_wvalid(wv),
      .s_axil_wready(wr_r), .s_axil_bresp(bresp), .s_axil_bvalid(bv), .s_axil_bready(br),
      .s_axil_araddr(ara), .s_axil_arvalid(arv), .s_axil_arready(arr), .s_axil_rdata(rd_d),
      .s_axil_rresp(rresp), .s_axil_rvalid(rv), .s_axil_rready(rr), .pin_in(pin),
      .pin_out(po), .pin_oe_n(oen), .pull_up_en(pu), .pull_down_en(pd), .vector_fetch(vf),
      .fetch_addr(fa), .break_state(brk), .irq_req(irq), .wake_req(wake));
   kic_keys keys (.clk(clk), .key_on(kon), .key_lvl(klv), .pin_out(po), .pin_oe_n(oen),
      .pull_up_en(pu), .pull_down_en(pd), .pin_lvl(pin));

   // Clock and watchdog.
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         miscompares++;
         finish_test();
      end
   end

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge clk);
      {awa, wd, awv, wv, br} <= {a, v, 3'b111};
      do
      begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr_r) wv <= 1'b0;
      end while (bv !== 1'b1);
      r = bresp;
      br <= 1'b0;
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      @(posedge clk);
      {ara, arv, rr} <= {a, 2'b11};
      do
      begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (rv !== 1'b1);
      d = rd_d;
      r = rresp;
      rr <= 1'b0;
      chk("rdata", d, e);
   endtask : rd

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test

   // Main sequence: reset values, the register rows, then the pin cases.
   initial
   begin
      {rst, awv, wv, br, arv, rr, vf, brk, kon, klv, awa, wd, ara} = '0;
      {miscompares, n_tests, cycles} = '0;
      fa = 16'hffe0;
      rst = 1'b1;
      cyc(3);
      rst <= 1'b0;
      for (int i = 0; i < 3; i++) rd(ra[i], 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         wr(ra[i], rw[i]);
         chk("bresp", r, i == 4 ? 2'b11 : 2'b00);
         rd(ra[i], re[i]);
         chk("rresp", r, i == 4 ? 2'b11 : 2'b00);
      end
      wr(32'h04, 32'hff);
      wr(32'h08, 32'h0f);
      cyc(2);
      chk("pull_up", pu, 8'hf0);
      chk("pull_down", pd, 8'h0f);
      $display("registers done");
      wr(32'h00, 32'h02);
      wr(32'h04, 32'h03);
      wr(32'h08, 32'h00);
      wr(32'h0c, 32'h00);
      wr(32'h00, 32'h06);
      wr(32'h00, 32'h00);
      kon <= 8'h01;
      cyc(6);
      chk("irq", irq, 1'b1);
      rd(32'h00, 32'h08);
      wr(32'h00, 32'h04);
      rd(32'h00, 32'h00);
      kon <= 8'h03;
      cyc(6);
      rd(32'h00, 32'h00);
      kon <= 8'h00;
      cyc(6);
      kon <= 8'h02;
      cyc(6);
      rd(32'h00, 32'h08);
      wr(32'h00, 32'h02);
      cyc(2);
      chk("irq", irq, 1'b0);
      chk("wake", wake, 1'b0);
      rd(32'h00, 32'h0a);
      wr(32'h00, 32'h00);
      cyc(2);
      chk("wake", wake, 1'b1);
      {vf, fa} <= {1'b1, 16'hffe2};
      @(posedge clk) vf <= 1'b0;
      rd(32'h00, 32'h08);
      {vf, fa} <= {1'b1, 16'hffe0};
      @(posedge clk) vf <= 1'b0;
      rd(32'h00, 32'h00);
      $display("edge mode done");
      {kon, brk} <= 9'h001;
      cyc(6);
      kon <= 8'h01;
      cyc(6);
      wr(32'h00, 32'h04);
      rd(32'h00, 32'h08);
      wr(32'h0c, 32'h01);
      wr(32'h00, 32'h04);
      brk <= 1'b0;
      rd(32'h00, 32'h00);
      kon <= 8'h00;
      wr(32'h08, 32'h01);
      wr(32'h00, 32'h01);
      cyc(6);
      wr(32'h00, 32'h05);
      {kon, klv} <= 16'h0101;
      cyc(6);
      wr(32'h00, 32'h05);
      rd(32'h00, 32'h09);
      kon <= 8'h00;
      cyc(6);
      rd(32'h00, 32'h01);
      kon <= 8'h01;
      cyc(6);
      rst <= 1'b1;
      cyc(3);
      rst <= 1'b0;
      rd(32'h00, 32'h00);
      wr(32'h10, 32'h03);
      wr(32'h04, 32'h01);
      cyc(2);
      chk("pin_oe_n", oen, 8'hfd);
      {kon, klv} <= 16'hff5a;
      wr(32'h14, 32'h01);
      cyc(4);
      rd(32'h14, 32'h59);
      chk("pin_out", po, 8'h01);
      $display("level mode done");
      finish_test();
   end
endmodule : tb_top
